// ==== core/dds_mod_pkg.sv ====
// Package: register map, field layout and modes of the modulation and power-down control
package dds_mod_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CHAN_CTRL = 8'h03;
  localparam logic [7:0] ADDR_FREQ_ZERO = 8'h04;
  localparam logic [7:0] ADDR_PHASE_ZERO = 8'h05;
  localparam logic [7:0] ADDR_AMP_ZERO = 8'h06;
  localparam logic [7:0] ADDR_PROFILE_FIRST = 8'h0A;
  localparam logic [7:0] ADDR_PROFILE_LAST = 8'h18;

  // Channel control field positions
  localparam int CC_MOD_TYPE_LO = 22;
  localparam int CC_SWEEP_EN = 14;
  localparam int CC_DAC_SCALE_LO = 8;
  localparam int CC_DAC_PD = 7;
  localparam int CC_DIGITAL_PD = 6;

  // Global control field positions
  localparam int GC_PLL_MULT_LO = 18;
  localparam int GC_PIN_MAP_LO = 12;
  localparam int GC_RAMP_SRC_LO = 10;
  localparam int GC_LEVEL_LO = 8;
  localparam int GC_CLK_IN_PD = 7;
  localparam int GC_PD_TYPE = 6;

  // Reset values
  localparam logic [23:0] CHAN_CTRL_RESET = 24'h000300;
  localparam logic [23:0] GLOBAL_CTRL_RESET = 24'h000000;

  // Multiplier limits and the one pin map that splits four levels
  localparam logic [4:0] PLL_MULT_MIN = 5'h04;
  localparam logic [4:0] PLL_MULT_MAX = 5'h14;
  localparam logic [2:0] MAP_SPLIT = 3'h5;

  // Profile word alignment
  localparam int PHASE_BITS = 14;
  localparam int AMP_BITS = 10;

  typedef enum logic [1:0] {MOD_OFF, MOD_AMP, MOD_FREQ, MOD_PHASE} mod_type_t;
  typedef enum logic [1:0] {LVL2, LVL4, LVL8, LVL16} level_t;
  typedef enum logic [1:0] {RAMP_OFF, RAMP_P23, RAMP_P3, RAMP_SDIO} ramp_src_t;

  // Per-channel output bundle
  typedef struct packed {
    logic [31:0] freq;
    logic [PHASE_BITS-1:0] phase;
    logic [AMP_BITS-1:0] amp;
    logic [3:0] profile;
    logic [1:0] dac_scale;
    logic ramp_en;
    logic ramp_down;
    logic digital_pd;
    logic dac_pd;
  } chan_out_t;

  // Chip-wide power-down bundle
  typedef struct packed {
    logic clk_in_pd;
    logic pll_pd;
    logic dac_bias_pd;
    logic osc_pd;
  } global_pd_t;

endpackage : dds_mod_pkg

// ==== core/dds_modulation_powerdown_ctrl.sv ====
// Modulation, ramp-source, DAC scaling and power-down control for two channels
// Behaviour
// - Per-channel two-bit DAC full-scale current scaling
// - Software bits power down clock, DAC, logic
// - Sleep pin high overrides software power-down bits
// - Fast sleep: logic and DAC logic off
// - Full sleep: every function including multiplier off
// - Bypassed clock multiplier is shut down
// - Power-down controls are active high
// - Profile pins select output profile level
// - Sixteen profile words, one onward at 0x0A-0x18
// - 0x04/0x05/0x06 supply profile zero word
// - Phase/amplitude words at 0x0A-0x18 MSB-aligned, low bits ignored
// - Modulation type: off, amplitude, frequency, phase
// - Level field: two, four, eight, sixteen
// - Ramp source: off, pins 2-3, pin 3, serial
// - Serial lines trigger ramps, never select profiles
// - Pin low ramps up, pin high ramps down
// - No amplitude ramp during amplitude modulation
// - Pin map field assigns pins to channels
// - Map 101 four-level splits pins between channels
// - Sixteen-level uses all pins for one channel
`timescale 1ns/1ps
`default_nettype none

module dds_modulation_powerdown_ctrl #(
  parameter int NUM_CHAN = 2,
  parameter int NUM_PROFILES = 16
) (
  // Clock, reset, enable
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic I_CLK_EN,
  // Register port
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [NUM_CHAN-1:0] I_REG_CHAN_SEL,
  output logic [31:0] O_REG_RDATA,
  // Pins from the controller
  input wire logic [3:0] I_PROFILE_PINS,
  input wire logic [3:1] I_SERIAL_LINES,
  input wire logic I_EXTERNAL_SLEEP_PIN,
  // Channel and chip outputs
  output dds_mod_pkg::chan_out_t [NUM_CHAN-1:0] O_CHAN,
  output dds_mod_pkg::global_pd_t O_GLOBAL_PD,
  output logic O_SERIAL_SINGLE_BIT
);
  import dds_mod_pkg::*;

  // Profile word zero is the dedicated register set, so the memory
  // holds one entry fewer than the profile count; an index of zero
  // never reaches the memory at all
  localparam int PW = NUM_PROFILES - 1;

  // Two-flop synchronisers for the asynchronous controller pins
  // Only the second stage feeds logic, so a metastable first stage
  // has a full cycle to settle; the cost is two cycles of latency on
  // every profile, ramp and sleep change
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic [3:1] sdio_meta_r;
  logic [3:1] sdio_sync_r;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      pin_meta_r <= 5'h00;
      pin_sync_r <= 5'h00;
      sdio_meta_r <= 3'h0;
      sdio_sync_r <= 3'h0;
    end else if (I_CLK_EN) begin
      pin_meta_r <= {I_EXTERNAL_SLEEP_PIN, I_PROFILE_PINS};
      pin_sync_r <= pin_meta_r;
      sdio_meta_r <= I_SERIAL_LINES;
      sdio_sync_r <= sdio_meta_r;
    end
  end

  wire [3:0] pr = pin_sync_r[3:0];
  wire sleep_pin = pin_sync_r[4];

  // Global control register
  logic [23:0] global_ctrl_r;
  wire wr_global = I_REG_WR && (I_REG_ADDR == ADDR_GLOBAL_CTRL);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      global_ctrl_r <= GLOBAL_CTRL_RESET;
    end else if (I_CLK_EN && wr_global) begin
      global_ctrl_r <= I_REG_WDATA[23:0];
    end
  end

  // Global field decode
  // All fields are plain slices of the stored word, so a write takes
  // effect on the outputs two edges later: one into the register and
  // one into the output flops
  // A multiplier value outside the legal range means bypass
  wire [4:0] pll_mult = global_ctrl_r[GC_PLL_MULT_LO +: 5];
  wire [2:0] pin_map = global_ctrl_r[GC_PIN_MAP_LO +: 3];
  wire ramp_src_t ramp_src = ramp_src_t'(global_ctrl_r[GC_RAMP_SRC_LO +: 2]);
  wire level_t level = level_t'(global_ctrl_r[GC_LEVEL_LO +: 2]);
  wire pd_full = global_ctrl_r[GC_PD_TYPE];
  wire pll_bypass = (pll_mult < PLL_MULT_MIN) || (pll_mult > PLL_MULT_MAX);

  // Sleep pin overrides the software bits; a one always means powered down
  // Fast sleep keeps bias, oscillator and clock input up so recovery is
  // quick; full sleep drops everything, including the multiplier, which
  // then needs its lock time again after wake-up
  // The clock input bit is a don't care while the pin is high
  wire sleep_fast = sleep_pin && !pd_full;
  wire sleep_full = sleep_pin && pd_full;
  wire clk_in_pd_nxt = sleep_pin ? sleep_full : global_ctrl_r[GC_CLK_IN_PD];
  wire pll_pd_nxt = sleep_full || pll_bypass;

  // Write decode shared by both channels
  // Channel registers share one address; the channel select bits pick
  // which copies take the write, so one access can program both
  // Writes to unmapped addresses fall through with no effect
  wire wr_chan = I_REG_WR && (I_REG_ADDR == ADDR_CHAN_CTRL);
  wire wr_freq = I_REG_WR && (I_REG_ADDR == ADDR_FREQ_ZERO);
  wire wr_phase = I_REG_WR && (I_REG_ADDR == ADDR_PHASE_ZERO);
  wire wr_amp = I_REG_WR && (I_REG_ADDR == ADDR_AMP_ZERO);
  wire in_prof = (I_REG_ADDR >= ADDR_PROFILE_FIRST) && (I_REG_ADDR <= ADDR_PROFILE_LAST);
  wire wr_prof = I_REG_WR && in_prof;
  wire [7:0] prof_off = I_REG_ADDR - ADDR_PROFILE_FIRST;
  wire [3:0] prof_sel = prof_off[3:0];

  // Per-channel storage, read by the register read mux below
  // The sweep enable bit is stored with the channel word but has no
  // effect here; software must keep it clear while modulating
  logic [23:0] chan_ctrl_r [NUM_CHAN];
  logic [31:0] freq_zero_r [NUM_CHAN];
  logic [PHASE_BITS-1:0] phase_zero_r [NUM_CHAN];
  logic [AMP_BITS-1:0] amp_zero_r [NUM_CHAN];
  logic [31:0] prof_mem [NUM_CHAN][PW];

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : gen_chan
      logic [3:0] idx;
      logic ramp_en;
      logic ramp_down;
      logic owner;
      logic [31:0] sel_word;
      chan_out_t out_nxt;
      chan_out_t out_r;
      wire mod_type_t mod_type = mod_type_t'(chan_ctrl_r[g][CC_MOD_TYPE_LO +: 2]);
      wire chan_we = I_REG_CHAN_SEL[g];

      // Register writes follow the channel select, like shared addresses
      always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
          chan_ctrl_r[g] <= CHAN_CTRL_RESET;
          freq_zero_r[g] <= 32'h00000000;
          phase_zero_r[g] <= '0;
          amp_zero_r[g] <= '0;
        end else if (I_CLK_EN && chan_we) begin
          if (wr_chan) chan_ctrl_r[g] <= I_REG_WDATA[23:0];
          if (wr_freq) freq_zero_r[g] <= I_REG_WDATA;
          if (wr_phase) phase_zero_r[g] <= I_REG_WDATA[PHASE_BITS-1:0];
          if (wr_amp) amp_zero_r[g] <= I_REG_WDATA[AMP_BITS-1:0];
        end
      end

      // Profile memory is data only, so it carries no reset
      always_ff @(posedge I_CLOCK) begin
        if (I_CLK_EN && chan_we && wr_prof) begin
          prof_mem[g][prof_sel] <= I_REG_WDATA;
        end
      end

      // Pin-to-channel routing; serial lines never reach the index
      // First pin of a group is the index MSB
      // Combinations the pin map does not support give index zero and
      // no ramp rather than a guess, so a misconfigured channel simply
      // stays on its profile zero words
      // Ramp outputs are levels that follow the trigger lines
      always_comb begin
        idx = 4'h0;
        ramp_en = 1'b0;
        ramp_down = 1'b0;
        owner = (pin_map[1:0] == {1'b1, g[0]});
        unique case (ramp_src)
          RAMP_OFF, RAMP_SDIO: begin
            unique case (level)
              LVL2: idx = {3'h0, pr[2+g]};
              LVL4: if (pin_map == MAP_SPLIT) idx = {2'h0, pr[2*g], pr[2*g+1]};
              LVL8: if (owner && ramp_src == RAMP_OFF) idx = {1'b0, pr[0], pr[1], pr[2]};
              LVL16: if (owner) idx = {pr[0], pr[1], pr[2], pr[3]};
            endcase
            if (ramp_src == RAMP_SDIO) begin
              unique case (level)
                LVL2: begin
                  ramp_en = sdio_sync_r[1] && (sdio_sync_r[2] == g[0]);
                  ramp_down = sdio_sync_r[3];
                end
                LVL4: begin
                  ramp_en = (pin_map == MAP_SPLIT);
                  ramp_down = sdio_sync_r[1+g];
                end
                LVL8: ramp_en = 1'b0;
                LVL16: begin
                  ramp_en = owner;
                  ramp_down = sdio_sync_r[1];
                end
              endcase
            end
          end
          RAMP_P23: begin
            if (level == LVL2 && pin_map == MAP_SPLIT) begin
              idx = {3'h0, pr[g]};
              ramp_en = 1'b1;
              ramp_down = pr[2+g];
            end
          end
          RAMP_P3: begin
            if (level == LVL8 && owner) begin
              idx = {1'b0, pr[0], pr[1], pr[2]};
              ramp_en = 1'b1;
              ramp_down = pr[3];
            end
          end
        endcase
        if (mod_type == MOD_OFF) idx = 4'h0;
        if (mod_type == MOD_AMP) ramp_en = 1'b0;
      end

      // Profile zero comes from the dedicated registers, others from memory
      assign sel_word = (idx == 4'h0) ? 32'h00000000 : prof_mem[g][idx - 4'h1];

      // Output word selection; phase and amplitude sit in the top bits
      // Low bits of a profile word are ignored for phase and amplitude
      // Only the modulated word follows the index; the others hold
      always_comb begin
        out_nxt = '0;
        out_nxt.freq = freq_zero_r[g];
        out_nxt.phase = phase_zero_r[g];
        out_nxt.amp = amp_zero_r[g];
        out_nxt.profile = idx;
        if (idx != 4'h0) begin
          unique case (mod_type)
            MOD_OFF: out_nxt.profile = 4'h0;
            MOD_AMP: out_nxt.amp = sel_word[31 -: AMP_BITS];
            MOD_FREQ: out_nxt.freq = sel_word;
            MOD_PHASE: out_nxt.phase = sel_word[31 -: PHASE_BITS];
          endcase
        end
        out_nxt.dac_scale = chan_ctrl_r[g][CC_DAC_SCALE_LO +: 2];
        out_nxt.ramp_en = ramp_en;
        out_nxt.ramp_down = ramp_down;
        out_nxt.digital_pd = sleep_pin ? 1'b1 : chan_ctrl_r[g][CC_DIGITAL_PD];
        out_nxt.dac_pd = sleep_pin ? 1'b1 : chan_ctrl_r[g][CC_DAC_PD];
      end

      // Registered so words change on one clean edge
      always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
          out_r <= '0;
        end else if (I_CLK_EN) begin
          out_r <= out_nxt;
        end
      end

      assign O_CHAN[g] = out_r;
    end
  endgenerate

  // Chip-wide power-down flops
  // Registered like the channel outputs so that chip and channel
  // power-down indications change on the same edge
  global_pd_t gpd_r;
  global_pd_t gpd_nxt;

  always_comb begin
    gpd_nxt.clk_in_pd = clk_in_pd_nxt;
    gpd_nxt.pll_pd = pll_pd_nxt;
    gpd_nxt.dac_bias_pd = sleep_full;
    gpd_nxt.osc_pd = sleep_full;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      gpd_r <= '0;
    end else if (I_CLK_EN) begin
      gpd_r <= gpd_nxt;
    end
  end

  assign O_GLOBAL_PD = gpd_r;

  // Serial single-bit mode is forced while the serial lines carry ramps
  logic single_bit_r;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      single_bit_r <= 1'b0;
    end else if (I_CLK_EN) begin
      single_bit_r <= (ramp_src == RAMP_SDIO);
    end
  end

  assign O_SERIAL_SINGLE_BIT = single_bit_r;

  // Read mux: lowest selected channel answers; unmapped reads zero
  // Read data is registered, so it belongs to the address presented
  // one cycle earlier; there is no read strobe, the mux runs always
  // Unwritten profile words read back unknown, as memory has no reset
  wire rd_ch = !I_REG_CHAN_SEL[0];
  wire [3:0] rd_idx = prof_sel;
  logic [31:0] rd_nxt;
  logic [31:0] rdata_r;

  always_comb begin
    rd_nxt = 32'h00000000;
    if (I_REG_ADDR == ADDR_GLOBAL_CTRL) rd_nxt = {8'h00, global_ctrl_r};
    else if (I_REG_ADDR == ADDR_CHAN_CTRL) rd_nxt = {8'h00, chan_ctrl_r[rd_ch]};
    else if (I_REG_ADDR == ADDR_FREQ_ZERO) rd_nxt = freq_zero_r[rd_ch];
    else if (I_REG_ADDR == ADDR_PHASE_ZERO) rd_nxt = {18'h00000, phase_zero_r[rd_ch]};
    else if (I_REG_ADDR == ADDR_AMP_ZERO) rd_nxt = {22'h000000, amp_zero_r[rd_ch]};
    else if (in_prof) rd_nxt = prof_mem[rd_ch][rd_idx];
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      rdata_r <= 32'h00000000;
    end else if (I_CLK_EN) begin
      rdata_r <= rd_nxt;
    end
  end

  assign O_REG_RDATA = rdata_r;

endmodule : dds_modulation_powerdown_ctrl

`default_nettype wire

// ==== sim/dds_pin_host.sv ====
// Host controller model driving the profile, sleep and spare serial pins
`timescale 1ns/1ps
`default_nettype none

module dds_pin_host (
  // Clock
  input wire logic i_clk,
  // Pins toward the device
  output logic [3:0] o_prof,
  output logic o_sleep,
  output logic [3:1] o_serial
);
  // Idle levels: awake, profile zero, no ramp trigger
  initial begin
    o_prof = 4'h0;
    o_sleep = 1'b0;
    o_serial = 3'h0;
  end

  // Levels move after a falling edge so the device never samples mid-change
  task automatic put(input logic [3:0] p, input logic s, input logic [3:1] l);
    @(negedge i_clk);
    o_prof = p;
    o_sleep = s;
    o_serial = l;
  endtask : put
endmodule : dds_pin_host

`default_nettype wire

// ==== sim/dds_mod_chk.sv ====
// Checker for the modulation and power-down control ports
`timescale 1ns/1ps
`default_nettype none

module dds_mod_chk #(
  parameter int NUM_CHAN = 2
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  // Watched inputs
  input wire logic I_REG_WR,
  input wire logic [3:0] I_PROFILE_PINS,
  input wire logic [3:1] I_SERIAL_LINES,
  input wire logic I_EXTERNAL_SLEEP_PIN,
  // Watched outputs
  input wire dds_mod_pkg::chan_out_t [NUM_CHAN-1:0] O_CHAN,
  input wire dds_mod_pkg::global_pd_t O_GLOBAL_PD,
  input wire logic O_SERIAL_SINGLE_BIT
);
  import dds_mod_pkg::*;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  // Pin paths are three flops deep, hence four samples of a steady level
  chk_sleep_chan_pd: assert property (
    I_EXTERNAL_SLEEP_PIN[*4] |-> O_CHAN[0].digital_pd && O_CHAN[0].dac_pd
      && O_CHAN[1].digital_pd && O_CHAN[1].dac_pd)
    else $error("sleep pin left channel logic powered");
  chk_awake_bias_up: assert property (
    (!I_EXTERNAL_SLEEP_PIN)[*4] |-> !O_GLOBAL_PD.osc_pd && !O_GLOBAL_PD.dac_bias_pd)
    else $error("bias or oscillator down while awake");
  chk_full_sleep_all: assert property (
    O_GLOBAL_PD.osc_pd |-> O_GLOBAL_PD.pll_pd && O_GLOBAL_PD.dac_bias_pd
      && O_GLOBAL_PD.clk_in_pd)
    else $error("full sleep left a chip function up");
  chk_full_sleep_chan: assert property (
    O_GLOBAL_PD.dac_bias_pd |-> O_CHAN[0].dac_pd && O_CHAN[1].dac_pd)
    else $error("bias down but a channel still up");
  chk_sleep_latency: assert property (
    $rose(I_EXTERNAL_SLEEP_PIN) |-> ##[2:3] O_CHAN[1].digital_pd)
    else $error("sleep pin not seen in time");
  chk_hold_when_idle: assert property (
    (!I_REG_WR && $stable(I_PROFILE_PINS) && $stable(I_SERIAL_LINES)
      && $stable(I_EXTERNAL_SLEEP_PIN))[*4]
    |-> $stable(O_CHAN) && $stable(O_GLOBAL_PD) && $stable(O_SERIAL_SINGLE_BIT))
    else $error("outputs moved with quiet inputs");
  chk_ramp_pin_level: assert property (
    ($stable(I_PROFILE_PINS[3])[*4] ##0 (O_CHAN[1].ramp_en && !O_SERIAL_SINGLE_BIT))
    |-> O_CHAN[1].ramp_down == I_PROFILE_PINS[3])
    else $error("ramp direction does not follow pin three");
  chk_reset_defaults: assert property (
    $fell(I_SRST) |=> O_CHAN[0].dac_scale == 2'h3 && O_CHAN[1].dac_scale == 2'h3
      && O_GLOBAL_PD.pll_pd)
    else $error("reset defaults wrong after release");

  // Main scenarios reached
  cov_full_sleep: cover property (O_GLOBAL_PD.osc_pd);
  cov_pin_ramp: cover property (O_CHAN[1].ramp_en && O_CHAN[1].ramp_down);
  cov_serial_ramp: cover property (O_SERIAL_SINGLE_BIT && O_CHAN[0].ramp_en);
endmodule : dds_mod_chk

bind dds_modulation_powerdown_ctrl dds_mod_chk #(.NUM_CHAN(NUM_CHAN)) chk_i (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_REG_WR(I_REG_WR),
  .I_PROFILE_PINS(I_PROFILE_PINS), .I_SERIAL_LINES(I_SERIAL_LINES),
  .I_EXTERNAL_SLEEP_PIN(I_EXTERNAL_SLEEP_PIN), .O_CHAN(O_CHAN),
  .O_GLOBAL_PD(O_GLOBAL_PD), .O_SERIAL_SINGLE_BIT(O_SERIAL_SINGLE_BIT));

`default_nettype wire

// ==== sim/dds_modulation_powerdown_ctrl_tb_top.sv ====
// Testbench: registers, pin modulation, ramps and power-down of the control block
`timescale 1ns/1ps
`default_nettype none

module dds_modulation_powerdown_ctrl_tb_top;
  import dds_mod_pkg::*;
  logic clk, rst, wr, slp, sb, ce;
  logic [7:0] ad;
  logic [31:0] wd, rdq;
  logic [1:0] sel;
  logic [3:0] pp;
  logic [3:1] sl;
  chan_out_t [1:0] ch;
  global_pd_t gp;
  int n_errors = 0;
  int n_compared = 0;

  // Host pins and the block
  dds_pin_host host (.i_clk(clk), .o_prof(pp), .o_sleep(slp), .o_serial(sl));
  dds_modulation_powerdown_ctrl uut (.I_CLOCK(clk), .I_SRST(rst), .I_CLK_EN(ce),
    .I_REG_WR(wr), .I_REG_ADDR(ad), .I_REG_WDATA(wd), .I_REG_CHAN_SEL(sel),
    .O_REG_RDATA(rdq), .I_PROFILE_PINS(pp), .I_SERIAL_LINES(sl),
    .I_EXTERNAL_SLEEP_PIN(slp), .O_CHAN(ch), .O_GLOBAL_PD(gp), .O_SERIAL_SINGLE_BIT(sb));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : ck

  // One-cycle write strobe, changed only at falling edges
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
    @(negedge clk);
    wr = 1'b1;
    ad = a;
    wd = d;
    sel = s;
    @(negedge clk);
    wr = 1'b0;
  endtask : w

  // Read data is registered: valid one edge after the address
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    ad = a;
    @(negedge clk);
    ck(rdq, e);
  endtask : r

  // Longest path is pin to output, three edges
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle

  task automatic pin(input logic [3:0] p, input logic s, input logic [3:1] l);
    host.put(p, s, l);
    settle();
  endtask : pin

  // Sweep bit left clear in every channel word
  function automatic logic [31:0] cc(input logic [1:0] t, sc, input logic dp, gd);
    cc = (32'(t) << CC_MOD_TYPE_LO) | (32'(sc) << CC_DAC_SCALE_LO)
      | (32'(dp) << CC_DAC_PD) | (32'(gd) << CC_DIGITAL_PD);
  endfunction : cc

  function automatic logic [31:0] gc(input logic [4:0] m, input logic [2:0] pm,
      input logic [1:0] rs, lv, input logic c, t);
    gc = (32'(m) << GC_PLL_MULT_LO) | (32'(pm) << GC_PIN_MAP_LO) | (32'(rs) << GC_RAMP_SRC_LO)
      | (32'(lv) << GC_LEVEL_LO) | (32'(c) << GC_CLK_IN_PD) | (32'(t) << GC_PD_TYPE);
  endfunction : gc

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Hang guard, far beyond the main sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [4:0] mt [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    ad = 8'h00;
    wd = 32'h0;
    sel = 2'h3;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    settle();
    r(ADDR_CHAN_CTRL, 32'(CHAN_CTRL_RESET));
    r(ADDR_GLOBAL_CTRL, 32'(GLOBAL_CTRL_RESET));
    r(8'h02, 32'h0);
    ck(gp.pll_pd, 1'b1);
    for (int i = 0; i < 4; i++) begin
      w(ADDR_CHAN_CTRL, cc(MOD_OFF, i[1:0], 1'b0, 1'b0), 2'h1);
      settle();
      ck({ch[0].dac_scale, ch[1].dac_scale}, {i[1:0], 2'h3});
    end
    // Software bits on channel one and clock input, then sleep overrides
    w(ADDR_CHAN_CTRL, cc(MOD_OFF, 2'h3, 1'b1, 1'b1), 2'h2);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, 3'h0, 2'h0, 2'h0, 1'b1, 1'b0), 2'h3);
    settle();
    ck({ch[1].dac_pd, ch[1].digital_pd, ch[0].dac_pd, ch[0].digital_pd, gp}, 8'hC8);
    pin(4'h0, 1'b1, 3'h0);
    ck({ch[0].dac_pd, ch[0].digital_pd, gp}, 6'h30);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, 3'h0, 2'h0, 2'h0, 1'b1, 1'b1), 2'h3);
    settle();
    ck({ch[0].dac_pd, ch[0].digital_pd, gp}, 6'h3F);
    pin(4'h0, 1'b0, 3'h0);
    ck({ch[1].dac_pd, ch[0].dac_pd, gp}, 6'h28);
    for (int i = 0; i < 4; i++) begin
      w(ADDR_GLOBAL_CTRL, gc(mt[i], 3'h0, 2'h0, 2'h0, 1'b0, 1'b0), 2'h3);
      settle();
      ck(gp.pll_pd, (i == 0 || i == 3));
    end
    // Two-level frequency modulation on both channels, then phase, amplitude and off on channel zero
    w(ADDR_CHAN_CTRL, cc(MOD_FREQ, 2'h3, 1'b0, 1'b0), 2'h3);
    w(ADDR_FREQ_ZERO, 32'h1111_2222, 2'h3);
    w(ADDR_PHASE_ZERO, 32'h0000_1ABC, 2'h3);
    w(ADDR_AMP_ZERO, 32'h0000_0155, 2'h3);
    w(ADDR_PROFILE_FIRST, 32'hA5C3_0F69, 2'h1);
    r(ADDR_PROFILE_FIRST, 32'hA5C3_0F69);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, 3'h7, 2'h0, LVL2, 1'b0, 1'b0), 2'h3);
    pin(4'h4, 1'b0, 3'h0);
    ck({ch[0].freq, ch[0].profile, ch[1].profile}, 40'hA5C30F6910);
    ck(ch[1].freq, 32'h1111_2222);
    w(ADDR_CHAN_CTRL, cc(MOD_PHASE, 2'h3, 1'b0, 1'b0), 2'h1);
    settle();
    ck(ch[0].phase, 14'h2970);
    w(ADDR_CHAN_CTRL, cc(MOD_AMP, 2'h3, 1'b0, 1'b0), 2'h1);
    settle();
    ck(ch[0].amp, 10'h297);
    pin(4'h0, 1'b0, 3'h0);
    ck(ch[0].amp, 10'h155);
    w(ADDR_CHAN_CTRL, cc(MOD_OFF, 2'h3, 1'b0, 1'b0), 2'h1);
    pin(4'h4, 1'b0, 3'h0);
    ck(ch[0].profile, 4'h0);
    // Four levels split by map 101, then sixteen on channel one
    w(ADDR_CHAN_CTRL, cc(MOD_FREQ, 2'h3, 1'b0, 1'b0), 2'h3);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, MAP_SPLIT, 2'h0, LVL4, 1'b0, 1'b0), 2'h3);
    pin(4'hB, 1'b0, 3'h0);
    ck({ch[0].profile, ch[1].profile}, 8'h31);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, 3'h3, 2'h0, LVL16, 1'b0, 1'b0), 2'h3);
    pin(4'h7, 1'b0, 3'h0);
    ck({ch[0].profile, ch[1].profile}, 8'h0E);
    // Ramps from pins two and three, then from the serial lines
    w(ADDR_GLOBAL_CTRL, gc(5'h04, MAP_SPLIT, RAMP_P23, LVL2, 1'b0, 1'b0), 2'h3);
    pin(4'h0, 1'b0, 3'h0);
    ck({ch[0].ramp_en, ch[0].ramp_down, ch[1].ramp_en, ch[1].ramp_down}, 4'hA);
    pin(4'hC, 1'b0, 3'h0);
    ck({ch[0].ramp_en, ch[0].ramp_down, ch[1].ramp_en, ch[1].ramp_down}, 4'hF);
    w(ADDR_CHAN_CTRL, cc(MOD_AMP, 2'h3, 1'b0, 1'b0), 2'h2);
    settle();
    ck(ch[1].ramp_en, 1'b0);
    w(ADDR_GLOBAL_CTRL, gc(5'h04, 3'h0, RAMP_SDIO, LVL2, 1'b0, 1'b0), 2'h3);
    pin(4'h4, 1'b0, 3'h5);
    ck({sb, ch[0].ramp_en, ch[0].ramp_down, ch[0].profile}, 7'h71);
    // Clock enable low freezes syncs and outputs; pins restored before it rises
    @(negedge clk);
    ce = 1'b0;
    pin(4'h0, 1'b0, 3'h5);
    ck(ch[0].profile, 4'h1);
    pin(4'h4, 1'b0, 3'h5);
    ce = 1'b1;
    pin(4'h0, 1'b0, 3'h5);
    ck(ch[0].profile, 4'h0);
    // Second reset in mid-run
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    settle();
    ck({ch[0].dac_scale, sb, gp.pll_pd}, 4'hD);
    close_out();
  end
endmodule : dds_modulation_powerdown_ctrl_tb_top

`default_nettype wire
